// File: logic/fcc_pkg.sv
// Constants and types for the configuration control block.
// Assumes a 50 MHz ref_clk and 32-bit APB register access.
package fcc_pkg;
   localparam int      CLK_HZ         = 50_000_000;
   localparam int      POR_TIMEOUT_MS = 100;
   localparam longint  POR_CYCLES_L   = longint'(POR_TIMEOUT_MS) * CLK_HZ / 1000;
   localparam int      POR_CYCLES     = int'(POR_CYCLES_L);
   localparam int      CONFIGURATION_CLOCK_HALF      = 4;
   localparam int      CONFIRM_TICKS  = 3;
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_LEN    = 8'h04;
   localparam logic [7:0]  OFS_RBLEN  = 8'h08;
   localparam logic [7:0]  OFS_STATUS = 8'h0c;
   localparam logic [7:0]  OFS_COUNT  = 8'h10;
   localparam int      CTRL_REPROG    = 0;
   localparam int      CTRL_RB_OFF    = 1;
   localparam int      CTRL_RB_ONCE   = 2;
   localparam logic [2:0]  CTRL_RESET  = 3'h1;
   localparam logic [23:0] LEN_RESET   = 24'h000100;
   localparam logic [23:0] RBLEN_RESET = 24'h000800;
   localparam logic [2:0]  MODE_SLAVE  = 3'h7;
   localparam logic [2:0]  MODE_PERIPH = 3'h5;
   localparam int      IN_PWR  = 0;
   localparam int      IN_RST  = 1;
   localparam int      IN_M0   = 2;
   localparam int      IN_M1   = 3;
   localparam int      IN_M2   = 4;
   localparam int      IN_TRIG = 5;
   localparam int      IN_DONE = 6;
   localparam int      IN_CONFIGURATION_CLOCK = 7;
   localparam int      IN_DIN  = 8;
   localparam int      IN_SELA = 9;
   localparam int      IN_SELB = 10;
   localparam int      IN_SELC = 11;
   localparam int      IN_WRN  = 12;
   localparam int      IN_D5   = 13;
   localparam int      IN_W    = 16;
   typedef enum logic [2:0] {
      ST_POR   = 3'b000,
      ST_INIT  = 3'b001,
      ST_LOAD  = 3'b011,
      ST_START = 3'b010,
      ST_USER  = 3'b110,
      ST_PDOWN = 3'b111
   } fcc_state_t;
endpackage

// File: logic/fcc_config_control.sv
// Configuration control: power-on wait, mode sampling, loading in
// master, slave and peripheral modes, startup, reprogram, readback.
// Assumes all pins are asynchronous to ref_clk; APB on ref_clk.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
module fcc_config_control #(
   parameter int POR_CYCLES = fcc_pkg::POR_CYCLES,
   parameter int CONFIGURATION_CLOCK_HALF  = fcc_pkg::CONFIGURATION_CLOCK_HALF
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Control pins
   input  wire logic        powerDownN,
   input  wire logic        resetPinN,
   input  wire logic        modeSelectBit0,
   input  wire logic        modeSelectBit1,
   input  wire logic        modeSelectBit2,
   input  wire logic        readbackTrigger,
   output logic             readbackDataN,
   output logic             highWhileConfiguring,
   output logic             lowWhileConfiguring,
   // Open-drain done / reprogram pin
   input  wire logic        doneIn,
   output logic             doneOut,
   output logic             doneOe,
   // Configuration clock pin
   input  wire logic        cfgClkIn,
   output logic             cfgClkOut,
   output logic             cfgClkOe,
   // Data pins
   input  wire logic        serialDataIn,
   output logic             chainDataOut,
   input  wire logic        periphSelectAN,
   input  wire logic        periphSelectBN,
   input  wire logic        periphSelectC,
   input  wire logic        periphWriteStrobeN,
   input  wire logic [2:0]  parDataHi,
   output logic      [15:0] memAddress,
   output logic             readClock,
   // Internal configuration store and fabric
   output logic      [7:0]  cfgByte,
   output logic             cfgByteValid,
   input  wire logic        readbackBit,
   output logic             readbackFetch,
   output logic             storageReset,
   output logic             ioEnable,
   output logic             configured
);

   if (POR_CYCLES < 1 || CONFIGURATION_CLOCK_HALF < 1 || CONFIGURATION_CLOCK_HALF > 255)
      $error("fcc_config_control: bad timing parameter");

   typedef struct packed {
      fcc_pkg::fcc_state_t     state;
      logic [fcc_pkg::IN_W-1:0] sync1;
      logic [fcc_pkg::IN_W-1:0] sync2;
      logic [fcc_pkg::IN_W-1:0] prev;
      logic [31:0] porCnt;
      logic [7:0]  divCnt;
      logic        configuration_clock;
      logic [2:0]  mode;
      logic [1:0]  step;
      logic [23:0] byteCnt;
      logic [2:0]  bitCnt;
      logic [7:0]  shift;
      logic [15:0] addr;
      logic [1:0]  confirm;
      logic        armed;
      logic        rbActive;
      logic        rbUsed;
      logic [23:0] rbCnt;
      logic [2:0]  ctrl;
      logic [23:0] len;
      logic [23:0] rbLen;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        rbDataN;
      logic        hwc;
      logic        lwc;
      logic        doneOe;
      logic        cclkOe;
      logic        chainOut;
      logic        readClk;
      logic [7:0]  cfgByte;
      logic        cfgValid;
      logic        rbFetch;
      logic        stReset;
      logic        ioEn;
      logic        done;
   } fcc_regs_t;

   localparam fcc_regs_t RST = '{
      state:   fcc_pkg::ST_POR,
      ctrl:    fcc_pkg::CTRL_RESET,
      len:     fcc_pkg::LEN_RESET,
      rbLen:   fcc_pkg::RBLEN_RESET,
      rbDataN: 1'b1,
      hwc:     1'b1,
      doneOe:  1'b1,
      stReset: 1'b1,
      configuration_clock:    1'b1,
      default: '0
   };

   fcc_regs_t r;
   fcc_regs_t next_r;
   logic [fcc_pkg::IN_W-1:0] rawIn;
   logic [fcc_pkg::IN_W-1:0] rise;
   logic [fcc_pkg::IN_W-1:0] fall;
   logic [fcc_pkg::IN_W-1:0] s;

   assign rawIn = {parDataHi, periphWriteStrobeN, periphSelectC,
                   periphSelectBN, periphSelectAN, serialDataIn,
                   cfgClkIn, doneIn, readbackTrigger,
                   modeSelectBit2, modeSelectBit1, modeSelectBit0,
                   resetPinN, powerDownN};
   // Edges only look at the second stage and its delayed copy
   assign s    = r.sync2;
   assign rise = r.sync2 & ~r.prev;
   assign fall = ~r.sync2 & r.prev;

   always_comb begin
      logic        tick;
      logic        slave;
      logic        periph;
      logic        strobes;
      logic        acc;
      logic        gotByte;
      logic [7:0]  newByte;
      logic [31:0] rd;
      tick    = 1'b0;
      slave   = (r.mode == fcc_pkg::MODE_SLAVE);
      periph  = (r.mode == fcc_pkg::MODE_PERIPH);
      strobes = ~s[fcc_pkg::IN_SELA] & ~s[fcc_pkg::IN_SELB] &
                s[fcc_pkg::IN_SELC] & ~s[fcc_pkg::IN_WRN];
      gotByte = 1'b0;
      newByte = r.shift;
      rd      = '0;
      acc     = psel & penable & r.pready;
      next_r  = r;
      next_r.sync1    = rawIn;
      next_r.sync2    = r.sync1;
      next_r.prev     = r.sync2;
      next_r.cfgValid = 1'b0;
      next_r.rbFetch  = 1'b0;

      // Divider, held at zero in peripheral load and power-down, doubles as the sampling oscillator
      if (r.divCnt == 8'(CONFIGURATION_CLOCK_HALF - 1)) begin
         next_r.divCnt = '0;
         next_r.configuration_clock   = ~r.configuration_clock;
         tick          = ~r.configuration_clock;
      end else begin
         next_r.divCnt = r.divCnt + 8'h01;
      end

      // APB: zero-wait, decode in setup, answer in access
      next_r.pready = psel & ~penable;
      if (psel & ~penable) begin
         next_r.pslverr = 1'b0;
         case (paddr)
            fcc_pkg::OFS_CTRL:   rd = {29'h0, r.ctrl};
            fcc_pkg::OFS_LEN:    rd = {8'h0, r.len};
            fcc_pkg::OFS_RBLEN:  rd = {8'h0, r.rbLen};
            fcc_pkg::OFS_STATUS: rd = {23'h0, r.rbUsed, r.rbActive,
                                       r.done, r.mode, r.state};
            fcc_pkg::OFS_COUNT:  rd = {8'h0, r.byteCnt};
            default:             next_r.pslverr = 1'b1;
         endcase
         next_r.prdata = rd;
      end
      if (acc & pwrite) begin
         case (paddr)
            fcc_pkg::OFS_CTRL:  next_r.ctrl  = pwdata[2:0];
            fcc_pkg::OFS_LEN:   next_r.len   = pwdata[23:0];
            fcc_pkg::OFS_RBLEN: next_r.rbLen = pwdata[23:0];
            default: ;
         endcase
      end

      case (r.state)
         fcc_pkg::ST_POR: begin
            next_r.porCnt = r.porCnt + 32'h1;
            if (r.porCnt >= 32'(POR_CYCLES - 1))
               next_r.state = fcc_pkg::ST_INIT;
         end
         fcc_pkg::ST_INIT: begin
            next_r.byteCnt = '0;
            next_r.bitCnt  = '0;
            next_r.addr    = '0;
            next_r.rbUsed  = 1'b0;
            next_r.done    = 1'b0;
            next_r.ioEn    = 1'b0;
            next_r.stReset = 1'b1;
            next_r.doneOe  = 1'b1;
            if (s[fcc_pkg::IN_RST]) begin
               next_r.mode  = s[fcc_pkg::IN_M2:fcc_pkg::IN_M0];
               next_r.state = fcc_pkg::ST_LOAD;
            end
         end
         fcc_pkg::ST_LOAD: begin
            if (slave) begin
               if (rise[fcc_pkg::IN_CONFIGURATION_CLOCK]) begin
                  newByte = {r.shift[6:0], s[fcc_pkg::IN_DIN]};
                  next_r.chainOut = r.shift[7];
                  next_r.shift  = newByte;
                  next_r.bitCnt = r.bitCnt + 3'h1;
                  gotByte       = (r.bitCnt == 3'h7);
               end
            end else if (periph) begin
               if (strobes & ~r.armed) begin
                  next_r.armed    = 1'b1;
                  next_r.configuration_clock     = 1'b0;
                  next_r.chainOut = r.shift[7];
               end else if (~strobes & r.armed) begin
                  newByte = {r.shift[6:0], s[fcc_pkg::IN_DIN]};
                  next_r.armed  = 1'b0;
                  next_r.configuration_clock   = 1'b1;
                  next_r.shift  = newByte;
                  next_r.bitCnt = r.bitCnt + 3'h1;
                  gotByte       = (r.bitCnt == 3'h7);
               end
               next_r.divCnt = '0;
            end else if (tick) begin
               newByte = {s[fcc_pkg::IN_D5+2:fcc_pkg::IN_D5],
                          s[fcc_pkg::IN_SELA], s[fcc_pkg::IN_SELB],
                          s[fcc_pkg::IN_SELC], s[fcc_pkg::IN_WRN],
                          s[fcc_pkg::IN_DIN]};
               next_r.shift    = newByte;
               next_r.chainOut = newByte[0];
               next_r.addr     = r.addr + 16'h1;
               gotByte         = 1'b1;
            end
            if (gotByte) begin
               next_r.cfgByte  = newByte;
               next_r.cfgValid = 1'b1;
               next_r.byteCnt  = r.byteCnt + 24'h1;
               if (r.byteCnt + 24'h1 >= r.len) begin
                  next_r.state = fcc_pkg::ST_START;
                  next_r.step  = '0;
               end
            end
            if (~s[fcc_pkg::IN_RST])
               next_r.state = fcc_pkg::ST_INIT;
         end
         fcc_pkg::ST_START: begin
            // Storage reset, then outputs, then done on the next divider tick
            case (r.step)
               2'h0: begin
                  next_r.stReset = 1'b1;
                  next_r.step    = 2'h1;
               end
               2'h1: begin
                  next_r.stReset = 1'b0;
                  next_r.ioEn    = 1'b1;
                  next_r.step    = 2'h2;
               end
               default: begin
                  if (tick) begin
                     next_r.doneOe = 1'b0;
                     next_r.done   = 1'b1;
                     next_r.armed  = 1'b0;
                     next_r.state  = fcc_pkg::ST_USER;
                  end
               end
            endcase
            if (~s[fcc_pkg::IN_RST] & ~r.done)
               next_r.state = fcc_pkg::ST_INIT;
         end
         fcc_pkg::ST_USER: begin
            next_r.stReset = ~s[fcc_pkg::IN_RST];
            // falling edge must stay low for three ticks
            if (s[fcc_pkg::IN_DONE]) begin
               next_r.armed   = 1'b1;
               next_r.confirm = '0;
            end else if (r.armed & tick) begin
               next_r.confirm = r.confirm + 2'h1;
               if (r.confirm == 2'(fcc_pkg::CONFIRM_TICKS - 1)) begin
                  next_r.armed   = 1'b0;
                  next_r.confirm = '0;
                  if (r.ctrl[fcc_pkg::CTRL_REPROG]) begin
                     next_r.ioEn   = 1'b0;
                     next_r.doneOe = 1'b1;
                     next_r.done   = 1'b0;
                     next_r.state  = fcc_pkg::ST_INIT;
                  end
               end
            end
            if (rise[fcc_pkg::IN_TRIG] & ~r.rbActive &
                ~r.ctrl[fcc_pkg::CTRL_RB_OFF] &
                ~(r.ctrl[fcc_pkg::CTRL_RB_ONCE] & r.rbUsed)) begin
               next_r.rbActive = 1'b1;
               next_r.rbUsed   = 1'b1;
               next_r.rbCnt    = '0;
            end
            if (r.rbActive & rise[fcc_pkg::IN_CONFIGURATION_CLOCK]) begin
               next_r.rbDataN = ~readbackBit;
               next_r.rbFetch = 1'b1;
               next_r.rbCnt   = r.rbCnt + 24'h1;
               if (r.rbCnt + 24'h1 >= r.rbLen)
                  next_r.rbActive = 1'b0;
            end
            if (~r.rbActive)
               next_r.rbDataN = 1'b1;
         end
         fcc_pkg::ST_PDOWN: begin
            next_r.ioEn    = 1'b0;
            next_r.stReset = 1'b1;
            next_r.doneOe  = 1'b0;
            next_r.rbActive = 1'b0;
            next_r.rbDataN  = 1'b1;
            next_r.divCnt   = '0;
            next_r.configuration_clock     = 1'b1;
            if (s[fcc_pkg::IN_PWR]) begin
               next_r.doneOe = 1'b1;
               next_r.step   = '0;
               next_r.state  = r.done ? fcc_pkg::ST_START : fcc_pkg::ST_INIT;
               next_r.done   = 1'b0;
            end
         end
         default: next_r.state = fcc_pkg::ST_POR;
      endcase

      // Configuration kept; outputs off, storage reset and done pin released while powered down; APB still answers
      if (~s[fcc_pkg::IN_PWR] & (r.state != fcc_pkg::ST_POR) &
          (r.state != fcc_pkg::ST_PDOWN)) begin
         next_r.state    = fcc_pkg::ST_PDOWN;
         next_r.ioEn     = 1'b0;
         next_r.stReset  = 1'b1;
         next_r.doneOe   = 1'b0;
         next_r.cfgValid = 1'b0;
      end

      next_r.hwc = ~next_r.done;
      next_r.lwc = next_r.done;
      next_r.cclkOe = (next_r.state == fcc_pkg::ST_LOAD) &
                      (next_r.mode != fcc_pkg::MODE_SLAVE);
      // Read clock only toggles while a master load runs
      next_r.readClk = (next_r.state == fcc_pkg::ST_LOAD) &
                       ~slave & ~periph & next_r.configuration_clock;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         r <= RST;
      else
         r <= next_r;
   end

   assign prdata               = r.prdata;
   assign pready               = r.pready;
   assign pslverr              = r.pslverr;
   assign readbackDataN        = r.rbDataN;
   assign highWhileConfiguring = r.hwc;
   assign lowWhileConfiguring  = r.lwc;
   assign doneOut              = 1'b0;
   assign doneOe               = r.doneOe;
   assign cfgClkOut            = r.configuration_clock;
   assign cfgClkOe             = r.cclkOe;
   assign chainDataOut         = r.chainOut;
   assign memAddress           = r.addr;
   assign readClock            = r.readClk;
   assign cfgByte              = r.cfgByte;
   assign cfgByteValid         = r.cfgValid;
   assign readbackFetch        = r.rbFetch;
   assign storageReset         = r.stReset;
   assign ioEnable             = r.ioEn;
   assign configured           = r.done;

endmodule

// File: tb/fcc_config_checker_sva.sv
// Assertion checker on the configuration control block's ports.
// Assumes one ref_clk domain with synchronous active-low rst_n.
`timescale 1ns/1ns
module fcc_config_checker (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Pins
   input wire logic        powerDownN,
   input wire logic        resetPinN,
   input wire logic        modeSelectBit0,
   input wire logic        modeSelectBit1,
   input wire logic        modeSelectBit2,
   input wire logic        readbackDataN,
   input wire logic        highWhileConfiguring,
   input wire logic        lowWhileConfiguring,
   input wire logic        doneOe,
   input wire logic        cfgClkOe,
   input wire logic        readClock,
   input wire logic [15:0] memAddress,
   input wire logic        chainDataOut,
   input wire logic [7:0]  cfgByte,
   input wire logic        cfgByteValid,
   // Fabric side
   input wire logic        readbackBit,
   input wire logic        readbackFetch,
   input wire logic        storageReset,
   input wire logic        ioEnable,
   input wire logic        configured
);
   default clocking dcb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_hdc_flag: assert property (highWhileConfiguring == !configured)
      else $error("high flag disagrees with configured");
   a_ldc_flag: assert property (lowWhileConfiguring == configured)
      else $error("low flag disagrees with configured");
   a_rb_inverted: assert property (readbackFetch |-> readbackDataN == !$past(readbackBit))
      else $error("readback data not inverted");
   a_rb_after_cfg: assert property (readbackFetch |-> configured)
      else $error("readback before configuration");
   a_pdown_float: assert property (!powerDownN [*6] |-> !ioEnable && storageReset && !doneOe)
      else $error("power-down state wrong");
   a_wake_order: assert property ($rose(ioEnable) |-> $past(storageReset) && !storageReset)
      else $error("outputs enabled before storage reset");
   a_done_later: assert property ($rose(configured) |-> $past(ioEnable) && !doneOe)
      else $error("done not one tick after startup");
   a_reprog_hold: assert property ($fell(configured) |-> doneOe)
      else $error("done pin not held low on reprogram");
   a_clk_drive: assert property (cfgClkOe |-> !configured
      && !(modeSelectBit0 && modeSelectBit1 && modeSelectBit2))
      else $error("clock driven in slave mode or after load");
   a_rclk_load: assert property ($rose(readClock) |-> cfgClkOe && !configured)
      else $error("read clock outside master load");
   a_addr_step: assert property ($changed(memAddress) && memAddress != 16'h0
      |-> memAddress == $past(memAddress) + 16'h1)
      else $error("address did not step by one");
   a_user_reset: assert property ((configured && !resetPinN) [*5] |-> storageReset)
      else $error("reset pin ignored after configuration");
   a_chain_master: assert property (cfgByteValid && !modeSelectBit0 && !modeSelectBit1
      && !modeSelectBit2 |-> chainDataOut == cfgByte[0])
      else $error("chain output not forwarding loaded data");

   cover property ($rose(configured));
   cover property (readbackFetch);
   cover property ($fell(configured));
   cover property (!powerDownN [*6]);
endmodule

// File: tb/fcc_cfg_source.sv
// Far-side model: serial bitstream source, readback clock and a
// parallel memory. The clock stands still low outside frames.
`timescale 1ns/1ns
module fcc_cfg_source (
   // Mode and address from the device
   input  wire logic        masterOn,
   input  wire logic [15:0] memAddress,
   // Pins toward the device
   output logic             srcClk,
   output logic      [7:0]  busByte
);
   logic serBit;

   initial begin
      srcClk = 1'b0;
      serBit = 1'b0;
   end

   // Strobes sit idle outside master mode: selects high, select C low
   always_comb begin
      if (masterOn)
         busByte = memAddress[7:0] ^ 8'h5a;
      else
         busByte = {3'b000, 4'b1101, serBit};
   end

   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         serBit = b[i];
         #80 srcClk = 1'b1;
         #80 srcClk = 1'b0;
      end
      // Released line shows the inverse, not the last bit
      serBit = ~b[0];
   endtask

   task automatic pulse_clk(input int n);
      for (int i = 0; i < n; i++) begin
         #80 srcClk = 1'b1;
         #80 srcClk = 1'b0;
      end
   endtask
endmodule

// File: tb/tb_fpga_config_control_pins.sv
// Self-checking bench for the configuration control block.
// Assumes the far-side model fcc_cfg_source and the bound checker.
`timescale 1ns/1ns
module tb_fpga_config_control_pins;
   localparam int POR = 20;
   logic        ref_clk = 1'b0;
   logic        rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, cfgByte, busByte;
   logic [31:0] pwdata, prdata, rd;
   logic        powerDownN, resetPinN, readbackTrigger, readbackDataN;
   logic        modeSelectBit0, modeSelectBit1, modeSelectBit2, readbackBit, readbackFetch;
   logic        highWhileConfiguring, lowWhileConfiguring, doneIn, doneOut, doneOe, doneLow;
   logic        cfgClkIn, cfgClkOut, cfgClkOe, srcClk, serialDataIn, chainDataOut;
   logic        periphSelectAN, periphSelectBN, periphSelectC, periphWriteStrobeN;
   logic        readClock, cfgByteValid, storageReset, ioEnable, configured;
   logic [2:0]  parDataHi, modeSel;
   logic [15:0] memAddress;
   logic [7:0]  sent[$], got[$];
   int          fail_count = 0;
   int          checks_done = 0;
   int          fetches = 0;
   int          seed;

   assign {modeSelectBit2, modeSelectBit1, modeSelectBit0} = modeSel;
   assign {parDataHi, periphSelectAN, periphSelectBN, periphSelectC,
           periphWriteStrobeN, serialDataIn} = busByte;
   // Open-drain done pin with pull-up; clock pin shared with the source
   assign doneIn = doneOe ? doneOut : !doneLow;
   assign cfgClkIn = cfgClkOe ? cfgClkOut : srcClk;

   fcc_config_control #(.POR_CYCLES(POR)) i_dut (.*);
   fcc_cfg_source i_src (.masterOn(modeSel == 3'h0), .memAddress(memAddress),
                         .srcClk(srcClk), .busByte(busByte));

   always #10 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (cfgByteValid === 1'b1)
         got.push_back(cfgByte);
      if (readbackFetch === 1'b1) begin
         fetches++;
         readbackBit <= $random(seed);
      end
   end

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
         n++;
         if (n > 20) begin
            fail_count++;
            wrap_up();
         end
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_bit(input bit sel, input logic v);
      int n;
      n = 0;
      while ((sel ? ioEnable : configured) !== v) begin
         @(posedge ref_clk);
         n++;
         if (n > 3000) begin
            fail_count++;
            wrap_up();
         end
      end
   endtask

   task automatic load(input int cnt);
      logic [7:0] b;
      for (int i = 0; i < cnt; i++) begin
         b = $random(seed);
         sent.push_back(b);
         // Link edges land on falling ref_clk edges, away from sampling
         @(negedge ref_clk);
         i_src.send_byte(b);
      end
      @(posedge ref_clk);
   endtask

   initial begin
      #1_800_000;
      fail_count++;
      wrap_up();
   end

   initial begin
      seed = 32'h4ab8f26c;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {powerDownN, resetPinN, readbackTrigger, readbackBit, doneLow} = 5'b10000;
      modeSel = 3'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      cmp("hwc", 1, highWhileConfiguring);
      cmp("ldc", 0, lowWhileConfiguring);
      apb(0, fcc_pkg::OFS_LEN, 0);
      cmp("len", 32'h100, rd);
      apb(0, fcc_pkg::OFS_RBLEN, 0);
      cmp("rblen", 32'h800, rd);
      apb(0, 8'h14, 32'hffff_ffff);
      cmp("unmapped", 1, err);
      apb(1, fcc_pkg::OFS_LEN, 4);
      apb(1, fcc_pkg::OFS_RBLEN, 8);
      repeat (POR + 10) @(posedge ref_clk);
      apb(0, fcc_pkg::OFS_STATUS, 0);
      cmp("held in init", 1, rd[2:0]);
      modeSel <= 3'h7;
      resetPinN <= 1'b1;
      repeat (5) @(posedge ref_clk);
      load(2);
      resetPinN <= 1'b0;
      repeat (5) @(posedge ref_clk);
      resetPinN <= 1'b1;
      repeat (5) @(posedge ref_clk);
      load(3);
      repeat (20) @(posedge ref_clk);
      cmp("restarted", 0, configured);
      load(1);
      wait_bit(0, 1'b1);
      cmp("byte count", 6, got.size());
      foreach (sent[i]) cmp("slave byte", sent[i], got[i]);
      apb(0, fcc_pkg::OFS_STATUS, 0);
      cmp("mode", 7, rd[5:3]);
      cmp("done released", 0, doneOe);
      apb(1, fcc_pkg::OFS_CTRL, 1);
      readbackTrigger <= 1'b1;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      i_src.pulse_clk(10);
      @(posedge ref_clk);
      cmp("readback bits", 8, fetches);
      resetPinN <= 1'b0;
      repeat (6) @(posedge ref_clk);
      cmp("user reset", 1, storageReset);
      resetPinN <= 1'b1;
      repeat (6) @(posedge ref_clk);
      cmp("kept config", 1, configured);
      powerDownN <= 1'b0;
      repeat (8) @(posedge ref_clk);
      cmp("pd outputs", 0, ioEnable);
      cmp("pd storage", 1, storageReset);
      powerDownN <= 1'b1;
      wait_bit(1, 1'b1);
      cmp("wake storage", 0, storageReset);
      wait_bit(0, 1'b1);
      modeSel <= 3'h0;
      got.delete();
      doneLow <= 1'b1;
      wait_bit(0, 1'b0);
      cmp("done held", 1, doneOe);
      doneLow <= 1'b0;
      wait_bit(0, 1'b1);
      cmp("master count", 4, got.size());
      foreach (got[i]) cmp("master byte", 8'(i) ^ 8'h5a, got[i]);
      wrap_up();
   end
endmodule

bind fcc_config_control fcc_config_checker i_chk (.*);
